// ### verilog/smpc_pkg.sv
// package for the stop mode power controller: offsets, fields, states
// assumes a 32-bit apb slave on pclk, registers one aligned word each
package smpc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] SMPC_SYSTEM_OPTIONS_OFS = 12'h000;
  localparam logic [11:0] SMPC_PM_STATUS_CTRL_OFS = 12'h004;
  localparam logic [11:0] SMPC_STOP_STATUS_OFS    = 12'h008;

  // system_options fields
  localparam int SMPC_WATCHDOG_ENABLE_BIT  = 7;
  localparam int SMPC_WATCHDOG_TIMEOUT_BIT = 6;
  localparam int SMPC_STOP_MODE_ENABLE_BIT = 5;
  localparam int SMPC_TIMER_ENABLE_BIT     = 1;
  localparam int SMPC_OSC_IN_STOP_BIT      = 0;

  // power_mgmt_status_control_2 fields
  localparam int SMPC_LVW_FLAG_BIT   = 7;
  localparam int SMPC_LVW_ACK_BIT    = 6;
  localparam int SMPC_LVD_SEL_BIT    = 5;
  localparam int SMPC_LVW_SEL_BIT    = 4;
  localparam int SMPC_PPD_FLAG_BIT   = 3;
  localparam int SMPC_PPD_ACK_BIT    = 2;
  localparam int SMPC_PDC_BIT        = 1;
  localparam int SMPC_PARTIAL_POWER_DOWN_CONTROL_BIT       = 0;

  // reset values
  localparam logic [7:0] SMPC_SYSTEM_OPTIONS_RST = 8'hc0;
  localparam logic [7:0] SMPC_PM_CTRL_RST        = 8'h00;

  // ---------------------------------------------------------------
  // stop depths and controller states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SMPC_DEPTH_NONE,
    SMPC_DEPTH_RETENTION,
    SMPC_DEPTH_PARTIAL,
    SMPC_DEPTH_FULL
  } smpc_depth_t;

  typedef enum {
    SMPC_RUN,
    SMPC_STOP_RET,
    SMPC_STOP_PPD,
    SMPC_STOP_FPD
  } smpc_state_t;

  // wake sources travel together
  typedef struct packed {
    logic ext_pin;
    logic periodic_wakeup_timer;
    logic keypad_interrupt;
    logic low_voltage_warning;
  } smpc_wake_t;

  // stop refusal and wake answers back to the core
  typedef struct packed {
    logic isr_resume;
    logic vector_reset;
    logic illegal_opcode_reset;
  } smpc_resume_t;

endpackage

// ### verilog/smpc_sync.sv
// three-stage synchroniser for an asynchronous pin level
// assumes one clock pclk; output changes when stages two and three agree
`timescale 1ns/1ps
module smpc_sync
  import smpc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);

  // ---------------------------------------------------------------
  // shift chain
  // ---------------------------------------------------------------
  logic s1;
  logic s2;
  logic s3;

  // stage one is read only by stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a change once two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end

endmodule

// ### verilog/smpc_depth_sel.sv
// picks the stop depth from the control bits and the detect enable
// assumes pure combinational use on pclk logic
`timescale 1ns/1ps
module smpc_depth_sel
  import smpc_pkg::*;
(
  input  wire logic  power_down_control,
  input  wire logic  partial_power_down_control,
  input  wire logic  lv_detect_enable,
  output smpc_depth_t depth
);

  // ---------------------------------------------------------------
  // depth decode
  // ---------------------------------------------------------------
  always_comb begin
    if (!power_down_control) begin
      depth = SMPC_DEPTH_RETENTION;
    end else if (lv_detect_enable) begin
      depth = SMPC_DEPTH_NONE;
    end else if (partial_power_down_control) begin
      depth = SMPC_DEPTH_PARTIAL;
    end else begin
      depth = SMPC_DEPTH_FULL;
    end
  end

endmodule

// ### verilog/smpc_top.sv
// stop mode power controller: apb registers, stop sequencing, wake
// assumes the core pulses stop_exec once per stop instruction on pclk
// and that wake sources and the reset pin are asynchronous levels
`timescale 1ns/1ps
module smpc_top
  import smpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_exec,
  input  wire logic        power_on_reset,
  input  wire logic        reset_pin_n,
  input  wire logic        ext_pin_raw,
  input  wire logic        ext_pin_active_high,
  input  wire logic        ext_pin_enable,
  input  wire logic        timer_wake_raw,
  input  wire logic        keypad_wake_raw,
  input  wire logic        keypad_partial_ok,
  input  wire logic        lvw_event_raw,
  input  wire logic        lvw_int_enable,
  input  wire logic        lv_detect_enable,
  output logic             core_clock_gate,
  output logic             peripheral_gate,
  output logic             timer_run,
  output logic             timer_use_osc,
  output logic             osc_enable,
  output logic             register_retain,
  output logic             ram_retain,
  output logic             pin_latch,
  output smpc_resume_t     resume
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // each level passes three flops and counts once stages two and
  // three agree, so a one-cycle glitch can never wake the core
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn_in;

  // the reset pin enters inverted: a cleared stage then reads as
  // released, so no false reset pin shows up right after presetn
  // bit order: 5 reset pin, 4 ext pin, 3 timer, 2 keypad, 1 warning, 0 por
  assign raw_in = {~reset_pin_n, ext_pin_raw, timer_wake_raw,
                   keypad_wake_raw, lvw_event_raw, power_on_reset};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      smpc_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_in[gi]),
        .q       (syn_in[gi])
      );
    end
  endgenerate

  smpc_state_t state;
  logic       rst_pin_low;
  logic       ext_level;
  smpc_wake_t wake;
  logic       por_seen;

  assign rst_pin_low = syn_in[5];
  assign ext_level   = syn_in[4];
  assign wake.periodic_wakeup_timer = syn_in[3];
  assign wake.keypad_interrupt      = syn_in[2];
  assign wake.low_voltage_warning   = syn_in[1];
  assign por_seen    = syn_in[0];
  // polarity is forced active low in full power-down; in every
  // other state the configured polarity applies
  assign wake.ext_pin = ext_pin_enable &
    ((state == SMPC_STOP_FPD) ? ~ext_level
                              : (ext_level ~^ ext_pin_active_high));

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  system_options;
  logic        power_down_control;
  logic        partial_power_down_control;
  logic        lv_detect_level_select;
  logic        lv_warning_level_select;
  logic        partial_power_down_flag;
  logic        low_voltage_warning_flag;
  smpc_depth_t depth;
  smpc_depth_t last_depth;
  logic        lvw_prev;
  logic        wr_en;
  logic        rd_en;
  logic        stop_mode_enable;
  logic        ppd_ack_wr;
  logic        lvw_ack_wr;
  logic        lvw_rise;
  logic        ppd_wake;

  // a write lands at the access edge, the one where pready is high;
  // a read is registered at the setup edge so prdata stands with pready
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;
  assign stop_mode_enable = system_options[SMPC_STOP_MODE_ENABLE_BIT];
  assign ppd_ack_wr = wr_en & (paddr == SMPC_PM_STATUS_CTRL_OFS)
                      & pwdata[SMPC_PPD_ACK_BIT];
  assign lvw_ack_wr = wr_en & (paddr == SMPC_PM_STATUS_CTRL_OFS)
                      & pwdata[SMPC_LVW_ACK_BIT];
  assign lvw_rise = wake.low_voltage_warning & ~lvw_prev;

  // a wake from either power-down depth or a genuine por puts the
  // registers back to power-on values; a reset-pin wake from
  // retention keeps them, since retention never lost them
  logic regs_to_por;
  assign regs_to_por = (resume.vector_reset &&
                        last_depth != SMPC_DEPTH_RETENTION) || por_seen;

  // depth is none while low-voltage detect is on and power_down_control is set, so stop is refused
  smpc_depth_sel u_depth (
    .power_down_control         (power_down_control),
    .partial_power_down_control (partial_power_down_control),
    .lv_detect_enable           (lv_detect_enable),
    .depth                      (depth)
  );

  // apb answers in the access cycle, no wait states: the setup cycle
  // raises pready, which stands for the whole access cycle, so every
  // transfer takes two edges; pslverr marks an unmapped offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable &
                 (paddr != SMPC_SYSTEM_OPTIONS_OFS) &
                 (paddr != SMPC_PM_STATUS_CTRL_OFS) &
                 (paddr != SMPC_STOP_STATUS_OFS);
    end
  end

  // control bits; internal registers return to power-on values
  // after waking from either power-down depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_options             <= SMPC_SYSTEM_OPTIONS_RST;
      power_down_control         <= 1'b0;
      partial_power_down_control <= 1'b0;
      lv_detect_level_select     <= 1'b0;
      lv_warning_level_select    <= 1'b0;
    end else if (regs_to_por) begin
      system_options             <= SMPC_SYSTEM_OPTIONS_RST;
      power_down_control         <= 1'b0;
      partial_power_down_control <= 1'b0;
      lv_detect_level_select     <= 1'b0;
      lv_warning_level_select    <= 1'b0;
    end else if (wr_en) begin
      if (paddr == SMPC_SYSTEM_OPTIONS_OFS) begin
        system_options <= pwdata[7:0];
      end else if (paddr == SMPC_PM_STATUS_CTRL_OFS) begin
        power_down_control         <= pwdata[SMPC_PDC_BIT];
        partial_power_down_control <= pwdata[SMPC_PARTIAL_POWER_DOWN_CONTROL_BIT];
        lv_detect_level_select     <= pwdata[SMPC_LVD_SEL_BIT];
        lv_warning_level_select    <= pwdata[SMPC_LVW_SEL_BIT];
      end
    end
  end

  // partial flag: set by partial wake only, cleared by ack or por;
  // software reads it after the reset vector to tell a partial wake
  // from a true power-on
  assign ppd_wake = (state == SMPC_STOP_PPD) &
                    (wake.ext_pin | wake.periodic_wakeup_timer |
                     (wake.keypad_interrupt & keypad_partial_ok));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partial_power_down_flag <= 1'b0;
    end else if (ppd_wake) begin
      partial_power_down_flag <= 1'b1;
    end else if (por_seen || ppd_ack_wr) begin
      partial_power_down_flag <= 1'b0;
    end
  end

  // warning flag: set on a rising warning, set wins over ack and
  // over the return to power-on values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvw_prev                 <= 1'b0;
      low_voltage_warning_flag <= 1'b0;
    end else begin
      lvw_prev <= wake.low_voltage_warning;
      if (lvw_rise) begin
        low_voltage_warning_flag <= 1'b1;
      end else if (lvw_ack_wr) begin
        low_voltage_warning_flag <= 1'b0;
      end else if (regs_to_por) begin
        low_voltage_warning_flag <= 1'b0;
      end
    end
  end

  // read mux, registered at the setup edge; unmapped offsets read 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == SMPC_SYSTEM_OPTIONS_OFS) begin
        prdata <= {24'h00_0000, system_options};
      end else if (paddr == SMPC_PM_STATUS_CTRL_OFS) begin
        prdata <= {24'h00_0000, low_voltage_warning_flag, 1'b0,
                   lv_detect_level_select, lv_warning_level_select,
                   partial_power_down_flag, 1'b0,
                   power_down_control, partial_power_down_control};
      end else if (paddr == SMPC_STOP_STATUS_OFS) begin
        prdata <= {28'h000_0000, last_depth, pin_latch, 1'b0};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // stop sequencer
  // ---------------------------------------------------------------
  // wake sets per depth; full power-down listens to the pin alone
  logic ret_wake;
  logic fpd_wake;
  assign ret_wake = wake.ext_pin | wake.periodic_wakeup_timer |
                    wake.keypad_interrupt |
                    (wake.low_voltage_warning & lvw_int_enable);
  assign fpd_wake = wake.ext_pin;

  // in run a stop is either refused with an illegal opcode reset or
  // taken into the depth the control bits pick; each stop state waits
  // for its own wake set and answers with a one-cycle resume pulse,
  // the reset pin winning over any interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= SMPC_RUN;
      last_depth <= SMPC_DEPTH_NONE;
      resume     <= '0;
    end else begin
      resume <= '0;
      case (state)
        SMPC_RUN: begin
          if (stop_exec && !stop_mode_enable) begin
            resume.illegal_opcode_reset <= 1'b1;
          end else if (stop_exec && depth == SMPC_DEPTH_NONE) begin
            resume.illegal_opcode_reset <= 1'b1;
          end else if (stop_exec) begin
            last_depth <= depth;
            if (depth == SMPC_DEPTH_RETENTION) begin
              state <= SMPC_STOP_RET;
            end else if (depth == SMPC_DEPTH_PARTIAL) begin
              state <= SMPC_STOP_PPD;
            end else begin
              state <= SMPC_STOP_FPD;
            end
          end
        end
        SMPC_STOP_RET: begin
          if (rst_pin_low) begin
            resume.vector_reset <= 1'b1;
            state <= SMPC_RUN;
          end else if (ret_wake) begin
            resume.isr_resume <= 1'b1;
            state <= SMPC_RUN;
          end
        end
        SMPC_STOP_PPD: begin
          if (rst_pin_low || ppd_wake) begin
            resume.vector_reset <= 1'b1;
            state <= SMPC_RUN;
          end
        end
        default: begin
          if (rst_pin_low || fpd_wake) begin
            resume.vector_reset <= 1'b1;
            state <= SMPC_RUN;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power and retention outputs
  // ---------------------------------------------------------------
  // configuration bits that the power outputs depend on
  logic timer_en;
  logic osc_in_stop;
  assign timer_en    = system_options[SMPC_TIMER_ENABLE_BIT];
  assign osc_in_stop = system_options[SMPC_OSC_IN_STOP_BIT];

  // all outputs follow the state one edge late and together, so the
  // gates and the retain levels never disagree for a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clock_gate <= 1'b0;
      peripheral_gate <= 1'b0;
      timer_run       <= 1'b0;
      timer_use_osc   <= 1'b0;
      osc_enable      <= 1'b1;
      register_retain <= 1'b1;
      ram_retain      <= 1'b1;
    end else begin
      core_clock_gate <= (state != SMPC_RUN);
      peripheral_gate <= (state != SMPC_RUN);
      timer_run <= (state == SMPC_RUN) ? timer_en :
                   (state == SMPC_STOP_FPD) ? 1'b0 : timer_en;
      // oscillator only survives retention stop when configured
      timer_use_osc <= (state == SMPC_STOP_RET) & osc_in_stop;
      osc_enable <= (state == SMPC_RUN) |
                    ((state == SMPC_STOP_RET) & osc_in_stop);
      register_retain <= (state == SMPC_RUN) |
                         (state == SMPC_STOP_RET);
      ram_retain <= (state != SMPC_STOP_FPD);
    end
  end

  // pins held from partial entry until acknowledged; the latch
  // survives the reset vector so software can first restore the
  // port registers from ram and only then release the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_latch <= 1'b0;
    end else if (state == SMPC_RUN && stop_exec && stop_mode_enable
                 && depth == SMPC_DEPTH_PARTIAL) begin
      pin_latch <= 1'b1;
    end else if (ppd_ack_wr && state == SMPC_RUN) begin
      pin_latch <= 1'b0;
    end
  end

endmodule

// ### tb/smpc_chk.sv
// checker: timing properties on the stop controller top ports
// assumes a bind into smpc_top, one clock pclk, async reset presetn
`timescale 1ns/1ps
module smpc_chk
  import smpc_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic  [11:0] paddr,
  input wire logic  [31:0] pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         power_on_reset,
  input wire logic         reset_pin_n,
  input wire logic         ext_pin_raw,
  input wire logic         ext_pin_enable,
  input wire logic         core_clock_gate,
  input wire logic         peripheral_gate,
  input wire logic         timer_run,
  input wire logic         timer_use_osc,
  input wire logic         osc_enable,
  input wire logic         register_retain,
  input wire logic         ram_retain,
  input wire logic         pin_latch,
  input wire smpc_resume_t resume
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ack_wr;
  // acknowledge write visible on the bus in either phase
  assign ack_wr = psel && pwrite && paddr == SMPC_PM_STATUS_CTRL_OFS
                  && pwdata[SMPC_PPD_ACK_BIT];
  chk_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready && penable)
    else $error("pslverr outside a completing access");
  chk_gates_agree: assert property (
    core_clock_gate == peripheral_gate)
    else $error("core and peripheral gates differ");
  chk_regs_lost_stop: assert property (
    !register_retain && ram_retain
    |-> core_clock_gate && !osc_enable && !timer_use_osc)
    else $error("partial stop left oscillator or run state");
  chk_full_off: assert property (
    !ram_retain |-> !register_retain && !timer_run && core_clock_gate)
    else $error("full power-down not fully off");
  chk_osc_only_ret: assert property (
    timer_use_osc |-> register_retain && osc_enable && core_clock_gate)
    else $error("timer on oscillator outside retention stop");
  chk_latch_held: assert property (
    pin_latch && !ack_wr && !power_on_reset |=> pin_latch)
    else $error("pin latch dropped without acknowledge");
  chk_isr_only_ret: assert property (
    resume.isr_resume |-> !resume.vector_reset && register_retain)
    else $error("service routine resume with lost registers");
  chk_full_pin_low: assert property (
    $fell(ext_pin_raw) && ext_pin_enable && !ram_retain && reset_pin_n
    |-> ##[1:8] resume.vector_reset)
    else $error("low pin did not wake full power-down");
  chk_vector_pulse: assert property (
    resume.vector_reset |=> !resume.vector_reset)
    else $error("vector resume longer than one cycle");
endmodule

bind smpc_top smpc_chk i_smpc_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .power_on_reset(power_on_reset),
  .reset_pin_n(reset_pin_n), .ext_pin_raw(ext_pin_raw),
  .ext_pin_enable(ext_pin_enable), .core_clock_gate(core_clock_gate),
  .peripheral_gate(peripheral_gate), .timer_run(timer_run),
  .timer_use_osc(timer_use_osc), .osc_enable(osc_enable),
  .register_retain(register_retain), .ram_retain(ram_retain),
  .pin_latch(pin_latch), .resume(resume));

// ### tb/smpc_far.sv
// far side model: core stop instruction and the four wake sources
// assumes the bench changes requests just after pclk edges
`timescale 1ns/1ps
module smpc_far
  import smpc_pkg::*;
(
  input  wire logic       stop_req,
  input  wire smpc_wake_t wake_req,
  input  wire logic       pin_active_high,
  output logic            stop_exec,
  output logic            ext_pin_raw,
  output logic            timer_wake_raw,
  output logic            keypad_wake_raw,
  output logic            lvw_event_raw
);
  // ---------------------------------------------------------------
  // core and wake sources
  // ---------------------------------------------------------------
  // core pulses stop for each cycle the bench requests it
  assign stop_exec = stop_req;
  // pin shows its configured active level only while requested
  assign ext_pin_raw = wake_req.ext_pin ~^ pin_active_high;
  // remaining sources are plain active-high levels
  assign timer_wake_raw = wake_req.periodic_wakeup_timer;
  assign keypad_wake_raw = wake_req.keypad_interrupt;
  assign lvw_event_raw = wake_req.low_voltage_warning;
endmodule

// ### tb/testbench.sv
// self-checking bench for the stop mode power controller
// assumes smpc_top with apb slave on pclk and the far side model
`timescale 1ns/1ps
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("MISMATCH %0t %h %h", $time, (a), (b)); \
  end \
end
module testbench
  import smpc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic  [11:0] paddr;
  logic  [31:0] pwdata, prdata, q, r;
  logic         stop_req, stop_exec, por, rst_pin_n, pol, lvd_en, lvw_en;
  logic         ext_raw, tmr_raw, kbd_raw, lvw_raw, hit, err, osc;
  logic         core_gate, per_gate, t_run, t_osc, osc_en, reg_ret;
  logic         ram_ret, latch, pin_en, kp_ok;
  smpc_wake_t   wake_req;
  smpc_resume_t resume;
  int           fails, samples_checked;
  localparam logic [11:0] SYS = SMPC_SYSTEM_OPTIONS_OFS;
  localparam logic [11:0] PM  = SMPC_PM_STATUS_CTRL_OFS;

  smpc_top i_smpc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_exec(stop_exec),
    .power_on_reset(por), .reset_pin_n(rst_pin_n),
    .ext_pin_raw(ext_raw), .ext_pin_active_high(pol),
    .ext_pin_enable(pin_en), .timer_wake_raw(tmr_raw),
    .keypad_wake_raw(kbd_raw), .keypad_partial_ok(kp_ok),
    .lvw_event_raw(lvw_raw), .lvw_int_enable(lvw_en),
    .lv_detect_enable(lvd_en), .core_clock_gate(core_gate),
    .peripheral_gate(per_gate), .timer_run(t_run),
    .timer_use_osc(t_osc), .osc_enable(osc_en),
    .register_retain(reg_ret), .ram_retain(ram_ret),
    .pin_latch(latch), .resume(resume));
  smpc_far i_smpc_far (
    .stop_req(stop_req), .wake_req(wake_req), .pin_active_high(pol),
    .stop_exec(stop_exec), .ext_pin_raw(ext_raw),
    .timer_wake_raw(tmr_raw), .keypad_wake_raw(kbd_raw),
    .lvw_event_raw(lvw_raw));

  // clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // readable image of the control register after a write
  function automatic logic [31:0] pm_img(input logic [7:0] w);
    return {24'h0, w & 8'h33};
  endfunction

  // one apb transfer; result left in q and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one stop instruction from the core
  task automatic do_stop;
    @(posedge pclk);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
  endtask

  // watch one resume bit over a bounded window
  task automatic wait_res(input int b);
    hit = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      if (resume[b] === 1'b1) hit = 1'b1;
    end
  endtask

  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    #500000;
    fails++;
    stop_test;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, stop_req, lvd_en, lvw_en} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {presetn, por, rst_pin_n, pol} = 4'h7;
    presetn = 1'b0;
    wake_req = 4'h0;
    {pin_en, kp_ok} = 2'h3;
    fails = 0;
    samples_checked = 0;
    void'($urandom(76927));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por <= 1'b0;
    apb(1'b0, SYS, 32'h0);
    `CHK(q, {24'h0, SMPC_SYSTEM_OPTIONS_RST})
    apb(1'b0, PM, 32'h0);
    `CHK(q, {24'h0, SMPC_PM_CTRL_RST})
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({err, q}, 33'h100000000) // unmapped read refused
    repeat (8) begin
      r = $urandom;
      apb(1'b1, PM, r);
      apb(1'b0, PM, 32'h0);
      `CHK(q, pm_img(r[7:0]))
    end
    apb(1'b1, SYS, 32'h0);
    do_stop;
    wait_res(0);
    `CHK(hit, 1'b1)
    r = $urandom;
    osc = r[0];
    pol <= r[1];
    lvw_en <= 1'b1;
    apb(1'b1, SYS, 32'h22 | {31'h0, osc});
    apb(1'b1, PM, {31'h0, r[2]});
    for (int s = 0; s < 4; s++) begin
      do_stop;
      repeat (2) @(posedge pclk);
      `CHK(core_gate, 1'b1)
      `CHK(per_gate, 1'b1)
      `CHK(reg_ret, 1'b1)
      `CHK(t_run, 1'b1)
      `CHK(t_osc, osc)
      wake_req <= 4'h8 >> s;
      wait_res(2);
      `CHK(hit, 1'b1)
      `CHK(core_gate, 1'b0)
      wake_req <= 4'h0;
      repeat (6) @(posedge pclk);
    end
    apb(1'b0, PM, 32'h0);
    `CHK(q, pm_img({7'h0, r[2]}) | 32'h80)
    apb(1'b1, PM, 32'h40);
    apb(1'b0, PM, 32'h0);
    `CHK(q, 32'h0)
    lvw_en <= 1'b0;
    do_stop;
    wake_req <= 4'h1;
    repeat (12) @(posedge pclk);
    `CHK(core_gate, 1'b1)
    rst_pin_n <= 1'b0;
    wait_res(1);
    `CHK(hit, 1'b1)
    rst_pin_n <= 1'b1;
    wake_req <= 4'h0;
    repeat (6) @(posedge pclk);
    lvd_en <= 1'b1;
    apb(1'b1, SYS, 32'h22);
    apb(1'b1, PM, 32'h43);
    do_stop;
    wait_res(0);
    `CHK(hit, 1'b1)
    lvd_en <= 1'b0;
    repeat (6) @(posedge pclk);
    do_stop;
    repeat (2) @(posedge pclk);
    `CHK({latch, reg_ret, ram_ret, osc_en}, 4'ha)
    `CHK(t_run, 1'b1)
    kp_ok <= 1'b0;
    wake_req <= 4'h2;
    repeat (12) @(posedge pclk);
    `CHK(core_gate, 1'b1)
    kp_ok <= 1'b1;
    wait_res(1);
    `CHK(hit, 1'b1)
    wake_req <= 4'h0;
    apb(1'b0, PM, 32'h0);
    `CHK(q, 32'h08)
    apb(1'b0, SYS, 32'h0);
    `CHK(q, {24'h0, SMPC_SYSTEM_OPTIONS_RST})
    apb(1'b0, SMPC_STOP_STATUS_OFS, 32'h0);
    `CHK(q, 32'h0a)
    apb(1'b1, PM, 32'h04);
    repeat (2) @(posedge pclk);
    `CHK(latch, 1'b0)
    apb(1'b0, PM, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b1, SYS, 32'h20);
    apb(1'b1, PM, 32'h02);
    pol <= 1'b1;
    wake_req <= 4'h8;
    repeat (6) @(posedge pclk);
    do_stop;
    repeat (2) @(posedge pclk);
    `CHK({reg_ret, ram_ret}, 2'h0)
    wake_req <= 4'ha;
    repeat (12) @(posedge pclk);
    `CHK(ram_ret, 1'b0)
    pin_en <= 1'b0;
    wake_req <= 4'h0;
    repeat (12) @(posedge pclk);
    `CHK(ram_ret, 1'b0)
    wake_req <= 4'h8;
    repeat (6) @(posedge pclk);
    pin_en <= 1'b1;
    wake_req <= 4'h0;
    wait_res(1);
    `CHK(hit, 1'b1)
    stop_test;
  end
endmodule
